// File: fgsf_consts.svh
`ifndef FGSF_CONSTS_SVH
`define FGSF_CONSTS_SVH
// register byte offsets
`define FGSF_CTRL 8'h00
`define FGSF_LOW_SET 8'h04
`define FGSF_FIN_SET 8'h08
`define FGSF_FIN_CLR 8'h0c
`define FGSF_CUR_THR 8'h10
`define FGSF_QUIT 8'h14
`define FGSF_RELAX 8'h18
`define FGSF_STATUS 8'h1c
`define FGSF_LOAD 8'h20
`define FGSF_LAST_RUN 8'h24
`define FGSF_RESERVE 8'h28
`define FGSF_QMAX0 8'h2c
`define FGSF_QMAX1 8'h30
`define FGSF_UPD 8'h34
`define FGSF_RATES 8'h38
`define FGSF_DESIGN 8'h3c
// field positions
`define FGSF_UPD_LEARNED 1
`define FGSF_UPD1_LEARNED 9
// reset values and the code that switches the final threshold off
`define FGSF_LOAD_MODE_RST 1'b0
`define FGSF_LOAD_SEL_RST 3'h1
`define FGSF_DSG_THR_RST 16'h0064
`define FGSF_CHG_THR_RST 16'h0032
`define FGSF_QUIT_RST 16'h000a
`define FGSF_DSG_RELAX_RST 13'h0708
`define FGSF_CHG_RELAX_RST 8'h3c
`define FGSF_QUIT_RELAX_RST 6'h01
`define FGSF_QMAX_RST 16'h05dc
`define FGSF_SET_OFF 16'hffff
// timing, limits, scale factors and bus response codes
`define FGSF_CLK_HZ 100000000
`define FGSF_OCV_S 1800
`define FGSF_DVDT_MAX 16'h0004
`define FGSF_FILT_SHIFT 4
`define FGSF_PWR_DIV 10000
`define FGSF_CAP_DIV 5
`define FGSF_OKAY 2'b00
`define FGSF_SLVERR 2'b10
`endif

// File: fgsf_host.sv
`timescale 1ns/1ns
module fgsf_host (
  input wire logic aclk, // clock
  output logic [7:0] awaddr, // aw addr
  output logic awvalid, // aw valid
  input wire logic awready, // aw ready
  output logic [31:0] wdata, // w data
  output logic [3:0] wstrb, // lanes
  output logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic [1:0] bresp, // b resp
  input wire logic bvalid, // b valid
  output logic bready, // b ready
  output logic [7:0] araddr, // ar addr
  output logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // r data
  input wire logic [1:0] rresp, // r resp
  input wire logic rvalid, // r valid
  output logic rready // r ready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // released payload is inverted so stale values cannot pass as live
  task automatic wr_word(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    join
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_word(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// File: fgsf_pkg.sv
package fgsf_pkg;
  typedef enum logic {FGSF_FLOW, FGSF_RELAXED} fgsf_mode_t;

  typedef struct packed {
    logic [15:0] rem_cap;
    logic rem_cap_valid;
    logic [15:0] avg_current;
    logic [15:0] voltage;
    logic [15:0] dvdt;
    logic [15:0] qmax_new;
    logic qmax_prof;
    logic qmax_valid;
  } fgsf_meas_t;

  typedef struct packed {
    logic capacity_low_flag;
    logic capacity_final_flag;
    logic load_model_status_bit;
    logic relaxed;
    logic ocv_window;
    logic discharging;
    logic charging;
    logic [15:0] load_value;
    logic [15:0] reserve_charge_amount;
    logic [15:0] reserve_energy_amount;
  } fgsf_flags_t;
endpackage

// File: fgsf_top.sv
`timescale 1ns/1ns
`include "fgsf_consts.svh"

module fgsf_top #(
  parameter int SEC_CYCLES = `FGSF_CLK_HZ
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire fgsf_pkg::fgsf_meas_t meas, // gauge core figures
  output fgsf_pkg::fgsf_flags_t flags // gauge decisions
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ld_mode;
    logic [2:0] ld_sel;
    logic [15:0] low_set;
    logic [15:0] fin_set;
    logic [15:0] fin_clr;
    logic [15:0] dsg_thr;
    logic [15:0] chg_thr;
    logic [15:0] quit;
    logic [12:0] dsg_relax;
    logic [7:0] chg_relax;
    logic [5:0] quit_relax;
    logic [15:0] host_rate;
    logic [15:0] user_rate;
    logic [15:0] dcap;
    logic [15:0] denergy;
    logic [15:0] res_chg;
    logic [15:0] res_en;
    logic [15:0] qmax0;
    logic [15:0] qmax1;
    logic [1:0] learned;
    logic low_f;
    logic fin_f;
    fgsf_pkg::fgsf_mode_t mode;
    logic last_dsg;
    logic in_dsg;
    logic in_chg;
    logic [31:0] tick;
    logic [15:0] below_s;
    logic [15:0] above_s;
    logic [15:0] relax_s;
    logic [15:0] filt;
    logic [39:0] isum;
    logic [39:0] psum;
    logic [23:0] cnt;
    logic [15:0] prev_i;
    logic [15:0] prev_p;
    logic [15:0] load;
    logic ocv;
  } fgsf_state_t;

  fgsf_state_t q, d;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

  // mA times mV gives uW; scaled to 10 mW units
  function automatic logic [15:0] pwr(input logic [15:0] i,
    input logic [15:0] v);
    logic [31:0] p;
    p = 32'(i) * 32'(v);
    return 16'(p / 32'(`FGSF_PWR_DIV));
  endfunction

  function automatic logic [15:0] mean(input logic [39:0] s,
    input logic [23:0] n);
    return 16'(s / 40'(n));
  endfunction

  function automatic logic [15:0] mag(input logic [15:0] x);
    return x[15] ? 16'(-x) : x;
  endfunction

  logic [31:0] wcur;
  logic [31:0] wv;
  logic [31:0] rv;
  logic rerr;
  logic werr;
  logic wr_go;
  logic sec;
  logic [15:0] pres_i;
  logic [15:0] pres_p;

  always_comb begin
    d = q;
    wcur = 32'h0000_0000;
    wv = 32'h0000_0000;
    rv = 32'h0000_0000;
    rerr = 1'b0;
    werr = 1'b0;
    sec = 1'b0;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    wr_go = q.aw_held && q.w_held && !q.bvalid;
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    case (q.aw_addr)
      `FGSF_CTRL: wcur = {28'h0, q.ld_sel, q.ld_mode};
      `FGSF_LOW_SET: wcur = {16'h0, q.low_set};
      `FGSF_FIN_SET: wcur = {16'h0, q.fin_set};
      `FGSF_FIN_CLR: wcur = {16'h0, q.fin_clr};
      `FGSF_CUR_THR: wcur = {q.chg_thr, q.dsg_thr};
      `FGSF_QUIT: wcur = {16'h0, q.quit};
      `FGSF_RELAX: wcur = {5'h0, q.quit_relax, q.chg_relax, q.dsg_relax};
      `FGSF_RESERVE: wcur = {q.res_en, q.res_chg};
      `FGSF_QMAX0: wcur = {16'h0, q.qmax0};
      `FGSF_QMAX1: wcur = {16'h0, q.qmax1};
      `FGSF_UPD: wcur = {22'h0, q.learned[1], 7'h0, q.learned[0], 1'b0};
      `FGSF_RATES: wcur = {q.user_rate, q.host_rate};
      `FGSF_DESIGN: wcur = {q.denergy, q.dcap};
      `FGSF_STATUS, `FGSF_LOAD, `FGSF_LAST_RUN: wcur = 32'h0000_0000;
      default: werr = 1'b1;
    endcase
    wv = wmerge(wcur, q.w_data, q.w_strb);

    if (wr_go) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = werr ? `FGSF_SLVERR : `FGSF_OKAY;
      case (q.aw_addr)
        `FGSF_CTRL: begin
          d.ld_mode = wv[0];
          d.ld_sel = wv[3:1];
        end
        `FGSF_LOW_SET: d.low_set = wv[15:0];
        `FGSF_FIN_SET: d.fin_set = wv[15:0];
        `FGSF_FIN_CLR: d.fin_clr = wv[15:0];
        `FGSF_CUR_THR: begin
          d.dsg_thr = wv[15:0];
          d.chg_thr = wv[31:16];
        end
        `FGSF_QUIT: d.quit = wv[15:0];
        `FGSF_RELAX: begin
          d.dsg_relax = wv[12:0];
          d.chg_relax = wv[20:13];
          d.quit_relax = wv[26:21];
        end
        `FGSF_RESERVE: begin
          d.res_chg = wv[15:0];
          d.res_en = wv[31:16];
        end
        `FGSF_QMAX0: d.qmax0 = wv[15:0];
        `FGSF_QMAX1: d.qmax1 = wv[15:0];
        `FGSF_UPD: begin
          // only bit one of the two low bytes exists, the rest reads zero
          d.learned = {wv[`FGSF_UPD1_LEARNED], wv[`FGSF_UPD_LEARNED]};
        end
        `FGSF_RATES: begin
          d.host_rate = wv[15:0];
          d.user_rate = wv[31:16];
        end
        `FGSF_DESIGN: begin
          d.dcap = wv[15:0];
          d.denergy = wv[31:16];
        end
        default: d.bresp = werr ? `FGSF_SLVERR : `FGSF_OKAY;
      endcase
    end

    // read channel
    case (s_axi_araddr)
      `FGSF_STATUS: rv = {25'h0, q.ocv, q.mode == fgsf_pkg::FGSF_RELAXED,
        q.in_chg, q.in_dsg, q.ld_mode, q.fin_f, q.low_f};
      `FGSF_LOAD: rv = {16'h0, q.load};
      `FGSF_LAST_RUN: rv = {q.prev_p, q.prev_i};
      `FGSF_CTRL: rv = {28'h0, q.ld_sel, q.ld_mode};
      `FGSF_LOW_SET: rv = {16'h0, q.low_set};
      `FGSF_FIN_SET: rv = {16'h0, q.fin_set};
      `FGSF_FIN_CLR: rv = {16'h0, q.fin_clr};
      `FGSF_CUR_THR: rv = {q.chg_thr, q.dsg_thr};
      `FGSF_QUIT: rv = {16'h0, q.quit};
      `FGSF_RELAX: rv = {5'h0, q.quit_relax, q.chg_relax, q.dsg_relax};
      `FGSF_RESERVE: rv = {q.res_en, q.res_chg};
      `FGSF_QMAX0: rv = {16'h0, q.qmax0};
      `FGSF_QMAX1: rv = {16'h0, q.qmax1};
      `FGSF_UPD: rv = {22'h0, q.learned[1], 7'h0, q.learned[0], 1'b0};
      `FGSF_RATES: rv = {q.user_rate, q.host_rate};
      `FGSF_DESIGN: rv = {q.denergy, q.dcap};
      default: rerr = 1'b1;
    endcase
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rv;
      d.rresp = rerr ? `FGSF_SLVERR : `FGSF_OKAY;
    end
    d.awready = !d.aw_held && !d.bvalid;
    d.wready = !d.w_held && !d.bvalid;
    d.arready = !d.rvalid;

    // capacity warnings, judged only on a fresh capacity figure
    if (meas.rem_cap_valid) begin
      if (meas.rem_cap < q.low_set) begin
        d.low_f = 1'b1;
      end else if (meas.rem_cap > q.low_set) begin
        d.low_f = 1'b0;
      end
      if (q.fin_set != `FGSF_SET_OFF) begin
        if (meas.rem_cap < q.fin_set) begin
          d.fin_f = 1'b1;
        end else if (q.fin_f && meas.rem_cap > q.fin_clr) begin
          d.fin_f = 1'b0;
        end
      end
    end

    // current direction, discharge taken as negative current
    d.in_dsg = $signed(meas.avg_current) < -$signed({1'b0, q.dsg_thr});
    d.in_chg = $signed(meas.avg_current) > $signed({1'b0, q.chg_thr});

    // one-second time base for relaxation timers and averaging
    if (q.tick >= 32'(SEC_CYCLES - 1)) begin
      d.tick = 32'h0;
      sec = 1'b1;
    end else begin
      d.tick = q.tick + 32'h1;
    end

    if (q.in_dsg) begin
      d.last_dsg = 1'b1;
    end else if (q.in_chg) begin
      d.last_dsg = 1'b0;
    end

    if (sec) begin
      // first-order filter; shift 4 is close to a 16 s constant
      d.filt = 16'($signed(q.filt) + (($signed(meas.avg_current) -
        $signed(q.filt)) >>> `FGSF_FILT_SHIFT));
      if (mag(meas.avg_current) < q.quit) begin
        d.above_s = 16'h0;
        if (q.below_s != 16'hffff) begin
          d.below_s = q.below_s + 16'h1;
        end
      end else begin
        d.below_s = 16'h0;
        if (q.above_s != 16'hffff) begin
          d.above_s = q.above_s + 16'h1;
        end
      end
      if (q.mode == fgsf_pkg::FGSF_RELAXED && q.relax_s != 16'hffff) begin
        d.relax_s = q.relax_s + 16'h1;
      end
      if (q.in_dsg) begin
        d.isum = q.isum + 40'(mag(meas.avg_current));
        d.psum = q.psum + 40'(pwr(mag(meas.avg_current), meas.voltage));
        d.cnt = q.cnt + 24'h1;
      end
    end

    // end of a discharge cycle logs its average and restarts
    if (q.cnt != 24'h0 && !q.in_dsg && q.in_chg) begin
      d.prev_i = mean(q.isum, q.cnt);
      d.prev_p = mean(q.psum, q.cnt);
      d.isum = 40'h0;
      d.psum = 40'h0;
      d.cnt = 24'h0;
    end

    case (q.mode)
      fgsf_pkg::FGSF_FLOW: begin
        // quiet time needed depends on the last flow direction
        if ((q.last_dsg && q.below_s >= 16'(q.dsg_relax)) ||
            (!q.last_dsg && q.below_s >= 16'(q.chg_relax))) begin
          d.mode = fgsf_pkg::FGSF_RELAXED;
          d.relax_s = 16'h0;
        end
      end
      fgsf_pkg::FGSF_RELAXED: begin
        if (q.above_s >= 16'(q.quit_relax) && q.above_s != 16'h0) begin
          d.mode = fgsf_pkg::FGSF_FLOW;
        end
      end
      default: d.mode = fgsf_pkg::FGSF_FLOW;
    endcase
    d.ocv = d.mode == fgsf_pkg::FGSF_RELAXED &&
      d.relax_s >= 16'(`FGSF_OCV_S);

    // new chemical capacity accepted only in a settled rest
    if (meas.qmax_valid && q.ocv &&
        $signed(meas.dvdt) < $signed(`FGSF_DVDT_MAX)) begin
      if (meas.qmax_prof) begin
        d.qmax1 = meas.qmax_new;
        d.learned[1] = 1'b1;
      end else begin
        d.qmax0 = meas.qmax_new;
        d.learned[0] = 1'b1;
      end
    end

    // load figure for compensation
    pres_i = q.cnt != 24'h0 ? mean(q.isum, q.cnt) : q.prev_i;
    pres_p = q.cnt != 24'h0 ? mean(q.psum, q.cnt) : q.prev_p;
    if (!q.ld_mode) begin
      case (q.ld_sel)
        3'h0: d.load = q.prev_i;
        3'h1: d.load = pres_i;
        3'h2: d.load = mag(meas.avg_current);
        3'h3: d.load = mag(q.filt);
        3'h4: d.load = 16'(q.dcap / 16'(`FGSF_CAP_DIV));
        3'h5: d.load = q.host_rate;
        3'h6: d.load = q.user_rate;
        default: d.load = pres_i;
      endcase
    end else begin
      case (q.ld_sel)
        3'h0: d.load = q.prev_p;
        3'h1: d.load = pres_p;
        3'h2: d.load = pwr(mag(meas.avg_current), meas.voltage);
        3'h3: d.load = pwr(mag(q.filt), meas.voltage);
        3'h4: d.load = 16'(q.denergy / 16'(`FGSF_CAP_DIV));
        3'h5: d.load = q.host_rate;
        3'h6: d.load = q.user_rate;
        default: d.load = pres_p;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ld_mode <= `FGSF_LOAD_MODE_RST;
      q.ld_sel <= `FGSF_LOAD_SEL_RST;
      q.dsg_thr <= `FGSF_DSG_THR_RST;
      q.chg_thr <= `FGSF_CHG_THR_RST;
      q.quit <= `FGSF_QUIT_RST;
      q.dsg_relax <= `FGSF_DSG_RELAX_RST;
      q.chg_relax <= `FGSF_CHG_RELAX_RST;
      q.quit_relax <= `FGSF_QUIT_RELAX_RST;
      q.qmax0 <= `FGSF_QMAX_RST;
      q.qmax1 <= `FGSF_QMAX_RST;
      q.mode <= fgsf_pkg::FGSF_FLOW;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign flags.capacity_low_flag = q.low_f;
  assign flags.capacity_final_flag = q.fin_f;
  assign flags.load_model_status_bit = q.ld_mode;
  assign flags.relaxed = q.mode == fgsf_pkg::FGSF_RELAXED;
  assign flags.ocv_window = q.ocv;
  assign flags.discharging = q.in_dsg;
  assign flags.charging = q.in_chg;
  assign flags.load_value = q.load;
  assign flags.reserve_charge_amount = q.res_chg;
  assign flags.reserve_energy_amount = q.res_en;

endmodule

// File: fgsf_top_monitor.sv
`timescale 1ns/1ns
`include "fgsf_consts.svh"
module fgsf_monitor (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic [7:0] s_axi_awaddr, // aw addr
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata, // w data
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire fgsf_pkg::fgsf_meas_t meas, // core figures
  input wire fgsf_pkg::fgsf_flags_t flags // decisions
);
  logic [15:0] low_q, fset_q, fclr_q;
  logic mode_q;
  logic take, pulse, dsg, chg, fin_on;
  // shadow only sees full words with both channels taken together
  assign take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready;
  assign pulse = meas.rem_cap_valid;
  assign fin_on = fset_q != `FGSF_SET_OFF;
  assign dsg = $signed(meas.avg_current) < -$signed(`FGSF_DSG_THR_RST);
  assign chg = $signed(meas.avg_current) > $signed(`FGSF_CHG_THR_RST);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_q <= 16'h0000;
      fset_q <= 16'h0000;
      fclr_q <= 16'h0000;
      mode_q <= `FGSF_LOAD_MODE_RST;
    end else if (take) begin
      case (s_axi_awaddr)
        `FGSF_LOW_SET: low_q <= s_axi_wdata[15:0];
        `FGSF_FIN_SET: fset_q <= s_axi_wdata[15:0];
        `FGSF_FIN_CLR: fclr_q <= s_axi_wdata[15:0];
        `FGSF_CTRL: mode_q <= s_axi_wdata[0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_LOW_SET: assert property (pulse && meas.rem_cap < low_q
    |=> flags.capacity_low_flag) else $error("low flag not set");
  AST_LOW_CLR: assert property (pulse && meas.rem_cap > low_q
    |=> !flags.capacity_low_flag) else $error("low flag not cleared");
  AST_FIN_SET: assert property (pulse && fin_on
    && meas.rem_cap < fset_q |=> flags.capacity_final_flag)
    else $error("final flag not set");
  AST_FIN_OFF: assert property (pulse && !fin_on
    |=> $stable(flags.capacity_final_flag)) else $error("final flag moved");
  AST_FIN_CLR: assert property (pulse && fin_on
    && flags.capacity_final_flag && meas.rem_cap > fclr_q
    && meas.rem_cap >= fset_q |=> !flags.capacity_final_flag)
    else $error("final flag not cleared");
  AST_MODE_MIRROR: assert property ($stable(mode_q) [*5]
    |-> flags.load_model_status_bit == mode_q) else $error("mode bit off");
  AST_DSG: assert property (1'b1 |=>
    flags.discharging == $past(dsg)) else $error("discharge state off");
  AST_CHG: assert property (1'b1 |=>
    flags.charging == $past(chg)) else $error("charge state off");
  AST_OCV: assert property (flags.ocv_window |-> flags.relaxed)
    else $error("ocv window outside relax");
  COV_FINAL: cover property (pulse && flags.capacity_final_flag);
  COV_RELAX: cover property ($rose(flags.relaxed));
  COV_OCV: cover property ($rose(flags.ocv_window));
endmodule
bind fgsf_top fgsf_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .meas(meas), .flags(flags));

// File: tb_fuel_gauge_state_flags.sv
`timescale 1ns/1ns
`include "fgsf_consts.svh"
module tb_fuel_gauge_state_flags;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  fgsf_pkg::fgsf_meas_t meas = '0;
  fgsf_pkg::fgsf_flags_t flags;
  int mismatches = 0;
  int samples_checked = 0;
  // {address, reset value}
  logic [39:0] rst_rows [7] = '{{`FGSF_CTRL, 32'h0000_0002},
    {`FGSF_CUR_THR, `FGSF_CHG_THR_RST, `FGSF_DSG_THR_RST},
    {`FGSF_QUIT, 16'h0000, `FGSF_QUIT_RST},
    {`FGSF_RELAX, 5'h00, `FGSF_QUIT_RELAX_RST, `FGSF_CHG_RELAX_RST,
     `FGSF_DSG_RELAX_RST},
    {`FGSF_QMAX0, 16'h0000, `FGSF_QMAX_RST},
    {`FGSF_QMAX1, 16'h0000, `FGSF_QMAX_RST}, {`FGSF_UPD, 32'h0000_0000}};
  // {capacity, low, final} with thresholds 100, 50 and 60
  logic [17:0] cap_rows [9] = '{{16'd120, 2'b00}, {16'd100, 2'b00},
    {16'd99, 2'b10}, {16'd50, 2'b10}, {16'd49, 2'b11}, {16'd60, 2'b11},
    {16'd61, 2'b10}, {16'd100, 2'b10}, {16'd101, 2'b00}};
  // {average current, discharging, charging}
  logic [17:0] cur_rows [4] = '{{16'hff9c, 2'b00}, {16'hff9b, 2'b10},
    {16'h0032, 2'b00}, {16'h0033, 2'b01}};
  // codes 4..6 per mode; design cap 1000, energy 3700
  logic [15:0] load_exp [6] = '{16'd200, 16'h0123, 16'h0456,
    16'd740, 16'h0123, 16'h0456};
  always #5 aclk = ~aclk;
  fgsf_top #(.SEC_CYCLES(10)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .meas(meas),
    .flags(flags));
  fgsf_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    i_host.rd_word(a, rd, resp);
    check(rd, exp);
  endtask
  task automatic cap(input logic [15:0] v);
    meas.rem_cap <= v;
    meas.rem_cap_valid <= 1'b1;
    @(posedge aclk);
    meas.rem_cap_valid <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic qmax(input logic [15:0] slope, input logic prof);
    meas.dvdt <= slope;
    meas.qmax_prof <= prof;
    meas.qmax_new <= 16'd1111;
    meas.qmax_valid <= 1'b1;
    @(posedge aclk);
    meas.qmax_valid <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    meas.voltage = 16'h0fa0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      rchk(rst_rows[i][39:32], rst_rows[i][31:0]);
    end
    i_host.wr_word(8'hfc, 32'h0000_0001, resp);
    check(32'(resp), 32'(`FGSF_SLVERR));
    i_host.rd_word(8'hfc, rd, resp);
    check({rd[29:0], resp}, {30'h0, `FGSF_SLVERR});
    $display("reset and map test done");
    i_host.wr_word(`FGSF_LOW_SET, 32'd100, resp);
    i_host.wr_word(`FGSF_FIN_SET, 32'd50, resp);
    i_host.wr_word(`FGSF_FIN_CLR, 32'd60, resp);
    for (int i = 0; i < 9; i++) begin
      cap(cap_rows[i][17:2]);
      check(32'({flags.capacity_low_flag, flags.capacity_final_flag}),
            32'(cap_rows[i][1:0]));
    end
    i_host.wr_word(`FGSF_FIN_SET, 32'h0000_ffff, resp);
    cap(16'd0);
    check(32'(flags.capacity_final_flag), 32'h0);
    i_host.wr_word(`FGSF_FIN_SET, 32'd50, resp);
    cap(16'd10);
    i_host.wr_word(`FGSF_FIN_SET, 32'h0000_ffff, resp);
    cap(16'd200);
    check(32'(flags.capacity_final_flag), 32'h1);
    $display("capacity flag test done");
    i_host.wr_word(`FGSF_DESIGN, 32'h0e74_03e8, resp);
    i_host.wr_word(`FGSF_RATES, 32'h0456_0123, resp);
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 7; c++) begin
        i_host.wr_word(`FGSF_CTRL, 32'(c * 2 + m), resp);
        repeat (4) @(posedge aclk);
        check(32'(flags.load_model_status_bit), 32'(m));
        if (c > 3) begin
          check(32'(flags.load_value), 32'(load_exp[m * 3 + c - 4]));
        end
      end
    end
    i_host.wr_word(`FGSF_RESERVE, 32'h0010_0020, resp);
    repeat (3) @(posedge aclk);
    check({flags.reserve_energy_amount, flags.reserve_charge_amount},
          32'h0010_0020);
    $display("load model test done");
    for (int i = 0; i < 4; i++) begin
      meas.avg_current <= cur_rows[i][17:2];
      repeat (3) @(posedge aclk);
      check(32'({flags.discharging, flags.charging}),
            32'(cur_rows[i][1:0]));
    end
    meas.avg_current <= 16'h0000;
    repeat (500) @(posedge aclk);
    check(32'(flags.relaxed), 32'h0);
    repeat (150) if (!flags.relaxed) @(posedge aclk);
    check(32'(flags.relaxed), 32'h1);
    repeat (17900) @(posedge aclk);
    check(32'(flags.ocv_window), 32'h0);
    repeat (300) if (!flags.ocv_window) @(posedge aclk);
    check(32'(flags.ocv_window), 32'h1);
    qmax(16'h0004, 1'b1);
    qmax(16'h0003, 1'b0);
    rchk(`FGSF_QMAX0, 32'd1111);
    rchk(`FGSF_QMAX1, 32'(`FGSF_QMAX_RST));
    rchk(`FGSF_UPD, 32'h0000_0002);
    meas.avg_current <= 16'hff38;
    repeat (40) if (flags.relaxed) @(posedge aclk);
    check(32'(flags.relaxed), 32'h0);
    repeat (50) @(posedge aclk);
    meas.avg_current <= 16'h0064;
    repeat (30) @(posedge aclk);
    rchk(`FGSF_LAST_RUN, {16'd80, 16'd200});
    i_host.wr_word(`FGSF_CTRL, 32'h0000_0000, resp);
    repeat (3) @(posedge aclk);
    check(32'(flags.load_value), 32'd200);
    i_host.wr_word(`FGSF_CTRL, 32'h0000_0005, resp);
    repeat (3) @(posedge aclk);
    check(32'(flags.load_value), 32'd40);
    rchk(`FGSF_STATUS, 32'h0000_0016);
    $display("relax and learning test done");
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    wrap_up();
  end
endmodule
